//--- hdl/tbt_framer.sv
`timescale 1ns/1ps
// Operation
// - accept blocks up to card receive limit
// - card receive limit defaults to 32
// - never send beyond terminal receive limit (a requested limit of 0 is accepted, yet blocks still carry 1 field byte)
// - terminal limit 32 at reset, adjustable
// - accept terminal limit request up to 254
// - reject 255 with R-block error 2
// - chain long responses in limited I-blocks
// - character waiting integer limited 0..5
// - gap between sent characters below CWT
// - reply after BGT, before BWT (a late core reply is still sent after BWT, with bwt_over set)
// - no reply window after WTX exchange
// - request WTX when processing runs long
// - LRC used, TC characters zero
// - accept command starting 22 etu later
// - bad EDC gives R-block error 1, but no reply if NAD or length is also bad and PCB nonzero
// - IFS response echoes requested size
// - only node address zero accepted
`include "tbt_defines.svh"
module tbt_framer
    import tbt_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] etu_clks, // card clocks per etu, from negotiated rate
    input wire logic [7:0] ifsc, // own receive limit announced in answer-to-reset
    input wire logic [3:0] cwi_cfg, // requested character waiting integer
    input wire logic [15:0] bwt_etu, // block waiting time in etu
    input wire logic rx_valid, // one received character
    input wire logic [7:0] rx_byte,
    output logic rx_block_done, // pulse: command block passed to the card core
    output logic [7:0] rx_inf_len,
    input wire logic rsp_valid, // response byte from the card core
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    output logic rsp_ready, // combinational take of response byte
    input wire logic busy_long, // core needs more than the block waiting time
    output logic tx_valid, // character to the line transmitter
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    output logic [7:0] ifsd_o, // current terminal receive limit
    output logic [7:0] atr_tb3, // answer-to-reset interface characters
    output logic [7:0] atr_tc,
    output logic wtx_active, // window check suspended
    output logic bwt_over // reply window missed
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tbt_state_t st_q, st_d;
    tbt_reply_t rep_q, rep_d;
    logic [7:0] ifsd_q, ifsd_d; // terminal receive limit
    logic [7:0] pos_q, pos_d; // byte index inside block
    logic [7:0] pcb_q, pcb_d; // received control byte
    logic [7:0] len_q, len_d; // received field length
    logic [7:0] req_q, req_d; // first field byte (ifs request)
    logic [7:0] lrc_q, lrc_d; // running xor check
    logic bad_q, bad_d; // addressing or size fault
    logic ns_q, ns_d; // send sequence bit
    logic [15:0] clk_q, clk_d; // clocks inside one etu
    logic [15:0] etu_q, etu_d; // etu since last event
    logic wtx_q, wtx_d;
    logic over_q, over_d;
    logic [7:0] cnt_q, cnt_d; // field bytes sent in current block
    logic [7:0] inf_q, inf_d; // field length of current transmit block
    logic [7:0] txb_q, txb_d;
    logic txv_q, txv_d;
    logic done_q, done_d;
    logic [7:0] rxl_q, rxl_d;
    logic [7:0] hold_q, hold_d; // response byte held for chaining
    logic hold_v_q, hold_v_d;
    logic last_q, last_d;

    // clip the waiting integer to the legal range
    function automatic logic [3:0] cwi_clip(input logic [3:0] v);
        cwi_clip = (v > `TBT_CWI_MAX) ? `TBT_CWI_MAX : v;
    endfunction

    // character waiting time = 11 + 2^cwi etu
    logic [15:0] cwt_etu;
    assign cwt_etu = 16'd11 + (16'd1 << cwi_clip(cwi_cfg));
    assign atr_tb3 = {4'h4, cwi_clip(cwi_cfg)};
    assign atr_tc = `TBT_TC_LRC;
    assign ifsd_o = ifsd_q;
    assign tx_valid = txv_q;
    assign tx_byte = txb_q;
    assign wtx_active = wtx_q;
    assign bwt_over = over_q;
    assign rx_block_done = done_q;
    assign rx_inf_len = rxl_q;
    // the core is drained only while an I-block field byte is due
    assign rsp_ready = (st_q == TBT_GUARD) && (rep_q == TBT_REP_I) && !hold_v_q;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic etu_tick;
        etu_tick = 1'b0;
        st_d = st_q; rep_d = rep_q; ifsd_d = ifsd_q; pos_d = pos_q;
        pcb_d = pcb_q; len_d = len_q; req_d = req_q; lrc_d = lrc_q;
        bad_d = bad_q; ns_d = ns_q; wtx_d = wtx_q; over_d = over_q;
        cnt_d = cnt_q; inf_d = inf_q; txb_d = txb_q; txv_d = 1'b0;
        done_d = 1'b0; rxl_d = rxl_q; hold_d = hold_q; hold_v_d = hold_v_q;
        last_d = last_q;
        // etu prescaler from the card clock
        clk_d = clk_q + 16'd1;
        if (clk_q + 16'd1 >= etu_clks) begin
            clk_d = 16'd0;
            etu_tick = 1'b1;
        end
        etu_d = etu_tick ? etu_q + 16'd1 : etu_q;
        if (rsp_ready && rsp_valid) begin
            hold_d = rsp_byte;
            hold_v_d = 1'b1;
            last_d = rsp_last;
        end
        unique case (st_q)
            TBT_IDLE, TBT_RX: begin
                // a block may start at any gap, 22 etu after our last included
                if (rx_valid) begin
                    etu_d = 16'd0;
                    clk_d = 16'd0;
                    st_d = TBT_RX;
                    lrc_d = (pos_q == 8'd0) ? rx_byte : lrc_q ^ rx_byte;
                    pos_d = pos_q + 8'd1;
                    if (pos_q == 8'd0) begin
                        bad_d = (rx_byte != `TBT_NAD_ZERO);
                    end else if (pos_q == 8'd1) begin
                        pcb_d = rx_byte;
                    end else if (pos_q == 8'd2) begin
                        len_d = rx_byte;
                        if (rx_byte > ifsc) bad_d = 1'b1;
                    end else if (pos_q == 8'd3) begin
                        req_d = rx_byte;
                    end
                    // the length byte is registered by now, so no stale length is compared
                    if (pos_q >= 8'd3 && pos_q == len_q + 8'd3) begin
                        st_d = TBT_DECIDE;
                        pos_d = 8'd0;
                    end
                end
            end
            TBT_DECIDE: begin
                etu_d = 16'd0;
                st_d = TBT_GUARD;
                if (bad_q && pcb_q != 8'h00 && lrc_q != 8'h00) begin
                    rep_d = TBT_REP_NONE; // address or size fault, nonzero PCB and bad check byte: stay silent
                end else if (lrc_q != 8'h00) begin
                    rep_d = TBT_REP_R_EDC;
                end else if (bad_q) begin
                    rep_d = TBT_REP_NONE;
                end else if (pcb_q == `TBT_PCB_S_IFS_REQ) begin
                    if (req_q == `TBT_IFSD_BAD) begin
                        rep_d = TBT_REP_R_OTHER;
                    end else begin
                        ifsd_d = req_q;
                        rep_d = TBT_REP_IFS;
                    end
                end else if (pcb_q == `TBT_PCB_S_WTX_RSP) begin
                    wtx_d = 1'b1;
                    rep_d = TBT_REP_I;
                end else if (!pcb_q[7]) begin
                    done_d = 1'b1;
                    rxl_d = len_q;
                    rep_d = TBT_REP_I;
                end else begin
                    rep_d = TBT_REP_I; // R-block ack continues the chain
                end
                // only the fresh decision counts; the stored kind is the previous block's
                if (rep_d == TBT_REP_NONE) st_d = TBT_IDLE;
            end
            TBT_GUARD: begin
                if (etu_q > `TBT_BGT_ETU) begin
                    if (rep_q != TBT_REP_I || hold_v_q) begin
                        st_d = TBT_TX_NAD;
                    end else if (busy_long && !wtx_q) begin
                        rep_d = TBT_REP_WTX;
                        st_d = TBT_TX_NAD;
                    end
                end
                if (etu_q >= bwt_etu && !wtx_q && st_d == TBT_GUARD) begin
                    over_d = 1'b1;
                end
            end
            TBT_TX_NAD, TBT_TX_PCB, TBT_TX_LEN, TBT_TX_INF, TBT_TX_EDC: begin
                // the first character is timed by the guard window, where the etu count runs
                // from the received block; the waiting bound applies inside a block only
                if (etu_q >= `TBT_SEND_GAP_ETU && (st_q == TBT_TX_NAD || etu_q < cwt_etu)
                    && tx_ready) begin
                    etu_d = 16'd0;
                    txv_d = 1'b1;
                    unique case (st_q)
                        TBT_TX_NAD: begin
                            txb_d = `TBT_NAD_ZERO;
                            lrc_d = `TBT_NAD_ZERO;
                            st_d = TBT_TX_PCB;
                            cnt_d = 8'd0;
                            inf_d = (rep_q == TBT_REP_IFS || rep_q == TBT_REP_WTX) ? 8'd1 : 8'd0;
                        end
                        TBT_TX_PCB: begin
                            unique case (rep_q)
                                TBT_REP_R_EDC: txb_d = `TBT_PCB_R_BASE | {4'h0, `TBT_R_ERR_EDC};
                                TBT_REP_R_OTHER: txb_d = `TBT_PCB_R_BASE | {4'h0, `TBT_R_ERR_OTHER};
                                TBT_REP_IFS: txb_d = `TBT_PCB_S_IFS_RSP;
                                TBT_REP_WTX: txb_d = `TBT_PCB_S_WTX_REQ;
                                default: txb_d = {1'b0, ns_q, !last_q, 5'h00};
                            endcase
                            lrc_d = lrc_q ^ txb_d;
                            st_d = TBT_TX_LEN;
                        end
                        TBT_TX_LEN: begin
                            // I-block length is counted as sent; only one byte known up front,
                            // so I-blocks here carry a single field byte each and chain
                            txb_d = (rep_q == TBT_REP_I) ? 8'd1 : inf_q;
                            inf_d = txb_d;
                            lrc_d = lrc_q ^ txb_d;
                            st_d = (txb_d == 8'd0) ? TBT_TX_EDC : TBT_TX_INF;
                        end
                        TBT_TX_INF: begin
                            txb_d = (rep_q == TBT_REP_IFS) ? ifsd_q :
                                    (rep_q == TBT_REP_WTX) ? 8'h01 : hold_q;
                            hold_v_d = 1'b0;
                            lrc_d = lrc_q ^ txb_d;
                            cnt_d = cnt_q + 8'd1;
                            if (cnt_q + 8'd1 >= inf_q) st_d = TBT_TX_EDC;
                        end
                        default: begin
                            txb_d = lrc_q;
                            if (rep_q == TBT_REP_I) begin
                                ns_d = !ns_q;
                                wtx_d = 1'b0;
                            end
                            st_d = TBT_IDLE;
                        end
                    endcase
                end
            end
            default: st_d = TBT_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= TBT_IDLE; rep_q <= TBT_REP_NONE;
            ifsd_q <= `TBT_IFS_DEFAULT;
            pos_q <= 8'h00; pcb_q <= 8'h00; len_q <= 8'h00; req_q <= 8'h00;
            lrc_q <= 8'h00; bad_q <= 1'b0; ns_q <= 1'b0;
            clk_q <= 16'h0000; etu_q <= 16'h0000; wtx_q <= 1'b0; over_q <= 1'b0;
            cnt_q <= 8'h00; inf_q <= 8'h00; txb_q <= 8'h00; txv_q <= 1'b0;
            done_q <= 1'b0; rxl_q <= 8'h00; hold_q <= 8'h00; hold_v_q <= 1'b0;
            last_q <= 1'b1;
        end else begin
            st_q <= st_d; rep_q <= rep_d; ifsd_q <= ifsd_d;
            pos_q <= pos_d; pcb_q <= pcb_d; len_q <= len_d; req_q <= req_d;
            lrc_q <= lrc_d; bad_q <= bad_d; ns_q <= ns_d;
            clk_q <= clk_d; etu_q <= etu_d; wtx_q <= wtx_d; over_q <= over_d;
            cnt_q <= cnt_d; inf_q <= inf_d; txb_q <= txb_d; txv_q <= txv_d;
            done_q <= done_d; rxl_q <= rxl_d; hold_q <= hold_d; hold_v_q <= hold_v_d;
            last_q <= last_d;
        end
    end
endmodule

//--- pkg/tbt_defines.svh
`ifndef TBT_DEFINES_SVH
`define TBT_DEFINES_SVH

// ----------------------------------------------------------------
// information field sizes
// ----------------------------------------------------------------
`define TBT_IFS_DEFAULT 8'h20
`define TBT_IFSD_MAX 8'hfe
`define TBT_IFSD_BAD 8'hff

// ----------------------------------------------------------------
// block control byte codings and the node address
// ----------------------------------------------------------------
`define TBT_PCB_R_BASE 8'h80
`define TBT_R_ERR_EDC 4'h1
`define TBT_R_ERR_OTHER 4'h2
`define TBT_PCB_S_IFS_REQ 8'hc1
`define TBT_PCB_S_IFS_RSP 8'he1
`define TBT_PCB_S_WTX_REQ 8'hc3
`define TBT_PCB_S_WTX_RSP 8'he3
`define TBT_PCB_NS_BIT 6
`define TBT_PCB_MORE_BIT 5
`define TBT_NAD_ZERO 8'h00

// ----------------------------------------------------------------
// answer-to-reset interface characters
// ----------------------------------------------------------------
`define TBT_CWI_MAX 4'h5
`define TBT_TC_LRC 8'h00

// ----------------------------------------------------------------
// timing, in elementary time units, and the reset etu length in clocks
// ----------------------------------------------------------------
`define TBT_BGT_ETU 16'd22
`define TBT_ETU_CLKS_RST 16'd372
`define TBT_SEND_GAP_ETU 16'd12

`endif

//--- pkg/tbt_pkg.sv
package tbt_pkg;
    // framer sequencing
    typedef enum logic [3:0] {
        TBT_IDLE, TBT_RX, TBT_DECIDE, TBT_GUARD, TBT_TX_NAD, TBT_TX_PCB,
        TBT_TX_LEN, TBT_TX_INF, TBT_TX_EDC
    } tbt_state_t;
    // kind of reply
    typedef enum logic [2:0] {
        TBT_REP_I, TBT_REP_R_EDC, TBT_REP_R_OTHER, TBT_REP_IFS, TBT_REP_WTX, TBT_REP_NONE
    } tbt_reply_t;
endpackage

//--- tb/tbt_framer_sva.sv
`timescale 1ns/1ps
module tbt_framer_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] etu_clks,
    input wire logic [7:0] ifsc,
    input wire logic [3:0] cwi_cfg,
    input wire logic rx_valid,
    input wire logic rx_block_done,
    input wire logic [7:0] rx_inf_len,
    input wire logic tx_valid,
    input wire logic [7:0] ifsd_o,
    input wire logic [7:0] atr_tb3,
    input wire logic [7:0] atr_tc,
    input wire logic bwt_over
);
    // ----------------------------------------------------------------
    // gap counters and checks on the card side
    // ----------------------------------------------------------------
    logic [31:0] rx_gap_q; // cycles since the last received character
    logic [31:0] rx_gap_d;
    logic [31:0] tx_gap_q; // cycles since the last sent character
    logic [31:0] tx_gap_d;
    // saturate so a long idle never wraps back into a small gap
    always_comb begin
        rx_gap_d = rx_valid ? 32'h0 : rx_gap_q + {31'h0, rx_gap_q != 32'hffff};
        tx_gap_d = tx_valid ? 32'h0 : tx_gap_q + {31'h0, tx_gap_q != 32'hffff};
    end
    // start high: the first character after reset has no predecessor
    always_ff @(posedge core_clk) begin
        rx_gap_q <= reset ? 32'hffff : rx_gap_d;
        tx_gap_q <= reset ? 32'hffff : tx_gap_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    rst_ifsd_a: assert property ($fell(reset) |-> ifsd_o == 8'h20)
        else $error("terminal limit not 32 after reset");
    cwi_clip_a: assert property (atr_tb3[3:0] == (cwi_cfg > 4'h5 ? 4'h5 : cwi_cfg))
        else $error("waiting integer out of range");
    tc_zero_a: assert property (atr_tc == 8'h00)
        else $error("error code character not zero");
    ifsd_max_a: assert property (ifsd_o <= 8'hfe)
        else $error("terminal limit above 254");
    char_gap_a: assert property (tx_valid |-> tx_gap_q + 32'h1 >= 32'(etu_clks) * 32'hc)
        else $error("sent characters too close");
    guard_time_a: assert property (tx_valid |-> rx_gap_q >= 32'(etu_clks) * 32'h16)
        else $error("reply inside guard time");
    bwt_sticky_a: assert property (bwt_over |=> bwt_over)
        else $error("window flag dropped");
    tx_pulse_a: assert property (tx_valid |=> !tx_valid)
        else $error("character strobe longer than one cycle");
    rx_len_a: assert property (rx_block_done |-> rx_inf_len <= ifsc)
        else $error("accepted field above own limit");
    cover property (rx_block_done);
    cover property (tx_valid);
    cover property ($fell(reset));
    cover property (bwt_over);
endmodule

//--- tb/tbt_term_model.sv
`timescale 1ns/1ps
module tbt_term_model (
    input wire logic core_clk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready
);
    // ----------------------------------------------------------------
    // terminal side: sends blocks, hears the card
    // ----------------------------------------------------------------
    logic [7:0] got_q [$]; // characters heard from the card
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b1; // the line always takes characters
    end
    // capture every card character
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1) begin
            got_q.push_back(tx_byte);
        end
    end
    // one whole block, check byte appended; bad flips it on purpose
    // the block protocol is the first one offered, so no selection exchange runs first
    task automatic send(input logic [7:0] b [$], input logic bad);
        logic [7:0] lrc;
        lrc = 8'h00;
        foreach (b[i]) begin
            lrc = lrc ^ b[i];
        end
        b.push_back(bad ? ~lrc : lrc);
        foreach (b[i]) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_byte <= b[i];
            @(posedge core_clk);
            rx_valid <= 1'b0;
            rx_byte <= ~b[i]; // stale data is not left on the line
            repeat (23) @(posedge core_clk); // 12 etu spacing
        end
    endtask
endmodule

//--- tb/tbt_framer_test.sv
`timescale 1ns/1ps
module tbt_framer_test;
    // ----------------------------------------------------------------
    // stimulus and checks
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] etu_clks = 16'h2; // short etu keeps the run brief
    logic [7:0] ifsc = 8'h20;
    logic [3:0] cwi_cfg = 4'h7; // above the legal range on purpose
    logic [15:0] bwt_etu = 16'h190;
    logic rsp_valid = 1'b0;
    logic [7:0] rsp_byte = 8'h00;
    logic rsp_last = 1'b0;
    logic busy_long = 1'b0;
    logic rx_valid, rx_block_done, rsp_ready, tx_valid, tx_ready, wtx_active, bwt_over;
    logic [7:0] rx_byte, rx_inf_len, tx_byte, ifsd_o, atr_tb3, atr_tc, len_q;
    int err_total = 0;
    int checked = 0;
    int done_n = 0;
    always #20 core_clk = ~core_clk;
    tbt_framer dut_u (.core_clk, .reset, .etu_clks, .ifsc, .cwi_cfg, .bwt_etu, .rx_valid,
        .rx_byte, .rx_block_done, .rx_inf_len, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready,
        .busy_long, .tx_valid, .tx_byte, .tx_ready, .ifsd_o, .atr_tb3, .atr_tc, .wtx_active,
        .bwt_over);
    tbt_term_model term_u (.core_clk, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready);
    // count accepted commands, keep the last field length
    always @(posedge core_clk) begin
        if (rx_block_done === 1'b1) begin
            done_n++;
            len_q <= rx_inf_len;
        end
    end
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic reset_dut;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        term_u.got_q.delete();
    endtask
    // wait, bounded, for a whole reply and compare it byte by byte
    task automatic expect_blk(input logic [7:0] e [$]);
        int n;
        n = 0;
        while (term_u.got_q.size() < e.size() && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        foreach (e[i]) begin
            chk8("reply", e[i], term_u.got_q.size() > i ? term_u.got_q[i] : 8'hxx);
        end
        term_u.got_q.delete();
    endtask
    // core offers one byte and holds it until taken
    task automatic core_rsp(input logic [7:0] b, input logic last);
        int n;
        n = 0;
        @(posedge core_clk);
        rsp_valid <= 1'b1;
        rsp_byte <= b;
        rsp_last <= last;
        @(negedge core_clk);
        while (rsp_ready !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        chk8("rsp_ready", 8'h01, {7'h0, rsp_ready});
        @(posedge core_clk);
        rsp_valid <= 1'b0;
    endtask
    // size request 254, then a command 22 etu later, first chained reply
    task automatic t_ifs;
        term_u.send('{8'h00, 8'hc1, 8'h01, 8'hfe}, 1'b0);
        expect_blk('{8'h00, 8'he1, 8'h01, 8'hfe, 8'h1e});
        chk8("ifsd", 8'hfe, ifsd_o);
        repeat (43) @(posedge core_clk); // 22 etu after the card's last character
        term_u.send('{8'h00, 8'h00, 8'h02, 8'h12, 8'h34}, 1'b0);
        chk8("done", 8'h01, 8'(done_n));
        chk8("len", 8'h02, len_q);
        core_rsp(8'h90, 1'b0);
        expect_blk('{8'h00, 8'h20, 8'h01, 8'h90, 8'hb1});
        term_u.send('{8'h00, 8'h90, 8'h00}, 1'b0);
        core_rsp(8'h00, 1'b1);
        expect_blk('{8'h00, 8'h40, 8'h01, 8'h00, 8'h41});
    endtask
    // bad check byte, size 255, foreign node address
    task automatic t_err;
        reset_dut;
        term_u.send('{8'h00, 8'h00, 8'h01, 8'haa}, 1'b1);
        expect_blk('{8'h00, 8'h81, 8'h00, 8'h81});
        term_u.send('{8'h00, 8'hc1, 8'h01, 8'hff}, 1'b0);
        expect_blk('{8'h00, 8'h82, 8'h00, 8'h82});
        chk8("ifsd", 8'h20, ifsd_o);
        term_u.send('{8'h01, 8'h00, 8'h01, 8'h55}, 1'b0);
        repeat (300) @(posedge core_clk);
        chk8("silent", 8'h00, 8'(term_u.got_q.size()));
        chk8("done", 8'h01, 8'(done_n));
        ifsc <= 8'h01;
        term_u.send('{8'h00, 8'h00, 8'h02, 8'h12, 8'h34}, 1'b0);
        repeat (300) @(posedge core_clk);
        chk8("silent", 8'h00, 8'(term_u.got_q.size()));
        chk8("done", 8'h01, 8'(done_n));
        ifsc <= 8'h20;
    endtask
    // command with no core answer: the reply window runs out
    task automatic t_bwt;
        reset_dut;
        term_u.send('{8'h00, 8'h00, 8'h01, 8'haa}, 1'b0);
        chk8("bwt", 8'h00, {7'h0, bwt_over});
        repeat (900) @(posedge core_clk);
        chk8("bwt", 8'h01, {7'h0, bwt_over});
    endtask
    // slow core: extension request, then the window is not judged
    task automatic t_wtx;
        reset_dut;
        busy_long <= 1'b1;
        term_u.send('{8'h00, 8'h00, 8'h01, 8'haa}, 1'b0);
        expect_blk('{8'h00, 8'hc3, 8'h01, 8'h01, 8'hc3});
        term_u.send('{8'h00, 8'he3, 8'h01, 8'h01}, 1'b0);
        repeat (1000) @(posedge core_clk);
        chk8("wtx", 8'h01, {7'h0, wtx_active});
        chk8("bwt", 8'h00, {7'h0, bwt_over});
        busy_long <= 1'b0;
        core_rsp(8'h90, 1'b1);
        expect_blk('{8'h00, 8'h00, 8'h01, 8'h90, 8'h91});
        chk8("wtx", 8'h00, {7'h0, wtx_active});
    endtask
    initial begin
        reset_dut;
        chk8("ifsd", 8'h20, ifsd_o);
        chk8("tb3", 8'h45, atr_tb3);
        chk8("tc", 8'h00, atr_tc);
        t_ifs;
        t_err;
        t_bwt;
        t_wtx;
        end_sim;
    end
    // watchdog: the tests need well under this span
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        end_sim;
    end
endmodule
bind tbt_framer tbt_framer_sva chk_u (.core_clk, .reset, .etu_clks, .ifsc, .cwi_cfg,
    .rx_valid, .rx_block_done, .rx_inf_len, .tx_valid, .ifsd_o, .atr_tb3, .atr_tc, .bwt_over);
